/* File: common/mwm_if.sv */
// Interface joining the sequencing controller and the arithmetic slice
interface mwm_if
  import mwm_pkg::*;
  (input logic clk);
  logic [OP_W-1:0] a_slice;
  logic [OP_W-1:0] b_slice;
  logic [SEL_W-1:0] op_select_code;
  logic [ACC_W-1:0] acc_out;
  logic acc_valid;
  modport slice (input a_slice, input b_slice, input op_select_code,
    output acc_out, output acc_valid);
  modport ctrl (output a_slice, output b_slice, output op_select_code,
    input acc_out, input acc_valid);
endinterface

/* File: common/mwm_pkg.sv */
// Package of constants and types for the multicycle wide multiplier
package mwm_pkg;
  localparam int OP_W = 18;
  localparam int PROD_W = 36;
  localparam int ACC_W = 48;
  localparam int SHIFT_W = 17;
  localparam int WIDE_W = 35;
  localparam int NARROW_W = 18;
  localparam int R53_W = 53;
  localparam int R70_W = 70;
  localparam int SEG_LO_W = 17;
  localparam int SEG_HI_W = 36;
  localparam int SEL_W = 7;
  // Select codes
  localparam logic [6:0] SEL_LOAD = 7'h05;
  localparam logic [6:0] SEL_ACC = 7'h25;
  localparam logic [6:0] SEL_SHACC = 7'h65;
  // Optional register stages around the multiplier (0 or 1 each)
  localparam int PIPE_IN = 0;
  localparam int PIPE_OUT = 0;
  typedef enum logic [1:0] {MODE_35X18, MODE_35X35, MODE_CPLX} mwm_mode_t;
endpackage

/* File: src/mwm_addsel.sv */
// Z selector and post adder of the slice
module mwm_addsel
  import mwm_pkg::*;
  (
  // Operands
  input wire logic [SEL_W-1:0] sel,
  input wire logic [PROD_W-1:0] prod,
  input wire logic [ACC_W-1:0] held,
  // Sum
  output logic [ACC_W-1:0] sum
  );
  logic [ACC_W-1:0] prod_ext;
  logic [ACC_W-1:0] z_val;
  // Product widened with its sign before the adder
  assign prod_ext = {{(ACC_W-PROD_W){prod[PROD_W-1]}}, prod};
  // Z selector; unknown codes fall back to a plain load
  always_comb begin
    case (sel)
      SEL_ACC: z_val = held;
      SEL_SHACC: z_val = ACC_W'($signed(held) >>> SHIFT_W);
      default: z_val = '0;
    endcase
  end
  assign sum = prod_ext + z_val;
endmodule

/* File: src/mwm_ctrl.sv */
// Sequencing controller: drives operand slices and select codes
module mwm_ctrl
  import mwm_pkg::*;
  (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // User request
  input wire logic start,
  input wire mwm_mode_t mode,
  input wire logic [WIDE_W-1:0] op_a,
  input wire logic [WIDE_W-1:0] op_b,
  input wire logic [NARROW_W-1:0] a_im,
  input wire logic [NARROW_W-1:0] b_im,
  // User results
  output logic busy,
  output logic seg_valid,
  output logic [1:0] seg_index,
  output logic [SEG_HI_W-1:0] seg_data,
  output logic done,
  output logic [R70_W-1:0] result,
  output logic [ACC_W-1:0] re_part,
  // Slice link
  mwm_if.ctrl lnk
  );
  localparam int LAT = 1 + PIPE_IN + PIPE_OUT;
  // ****************************************
  // Issue sequencer
  // ****************************************
  typedef enum logic [2:0] {ST_IDLE, ST_C1, ST_C2, ST_C3, ST_C4, ST_WAIT} mwm_st_t;
  mwm_st_t st_d, st_q;
  mwm_mode_t md_d, md_q;
  logic [WIDE_W-1:0] a_d, a_q, b_d, b_q;
  logic [NARROW_W-1:0] ai_d, ai_q, bi_d, bi_q;
  logic [OP_W-1:0] oa_d, oa_q, ob_d, ob_q;
  logic [SEL_W-1:0] os_d, os_q;
  logic [2:0] cyc_d, cyc_q;
  logic iss_d, iss_q;
  logic last_d, last_q;
  // Lower piece with its top bit forced to zero
  function automatic logic [OP_W-1:0] lo_piece(input logic [WIDE_W-1:0] v);
    lo_piece = {1'b0, v[SHIFT_W-1:0]};
  endfunction
  function automatic logic [OP_W-1:0] hi_piece(input logic [WIDE_W-1:0] v);
    hi_piece = v[WIDE_W-1:SHIFT_W];
  endfunction
  always_comb begin
    st_d = st_q;
    md_d = md_q;
    a_d = a_q;
    b_d = b_q;
    ai_d = ai_q;
    bi_d = bi_q;
    oa_d = '0;
    ob_d = '0;
    os_d = SEL_LOAD;
    cyc_d = 3'h0;
    iss_d = 1'b0;
    last_d = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (start) begin
          st_d = ST_C1;
          md_d = mode;
          a_d = op_a;
          b_d = op_b;
          ai_d = a_im;
          bi_d = b_im;
        end
      end
      ST_C1, ST_C2, ST_C3, ST_C4: begin
        iss_d = 1'b1;
        cyc_d = 3'(st_q - ST_C1);
        case (md_q)
          MODE_35X18: begin
            oa_d = (st_q == ST_C1) ? lo_piece(a_q) : hi_piece(a_q);
            ob_d = b_q[OP_W-1:0];
            os_d = (st_q == ST_C1) ? SEL_LOAD : SEL_SHACC;
            last_d = (st_q == ST_C2);
          end
          MODE_35X35: begin
            oa_d = (st_q == ST_C1 || st_q == ST_C3) ? lo_piece(a_q) : hi_piece(a_q);
            ob_d = (st_q == ST_C1 || st_q == ST_C2) ? lo_piece(b_q) : hi_piece(b_q);
            os_d = (st_q == ST_C1) ? SEL_LOAD : (st_q == ST_C3) ? SEL_ACC : SEL_SHACC;
            last_d = (st_q == ST_C4);
          end
          default: begin
            oa_d = (st_q == ST_C1 || st_q == ST_C3) ? a_q[OP_W-1:0] : ai_q;
            ob_d = (st_q == ST_C1 || st_q == ST_C4) ? b_q[OP_W-1:0] : bi_q;
            os_d = (st_q == ST_C1 || st_q == ST_C3) ? SEL_LOAD : SEL_ACC;
            last_d = (st_q == ST_C4);
          end
        endcase
        if (last_d) st_d = ST_WAIT;
        else st_d = mwm_st_t'(st_q + 3'h1);
      end
      ST_WAIT: if (done) st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= ST_IDLE;
      md_q <= MODE_35X18;
      a_q <= '0;
      b_q <= '0;
      ai_q <= '0;
      bi_q <= '0;
      oa_q <= '0;
      ob_q <= '0;
      os_q <= SEL_LOAD;
      cyc_q <= '0;
      iss_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      st_q <= st_d;
      md_q <= md_d;
      a_q <= a_d;
      b_q <= b_d;
      ai_q <= ai_d;
      bi_q <= bi_d;
      oa_q <= oa_d;
      ob_q <= ob_d;
      os_q <= os_d;
      cyc_q <= cyc_d;
      iss_q <= iss_d;
      last_q <= last_d;
    end
  end
  assign lnk.a_slice = oa_q;
  assign lnk.b_slice = ob_q;
  assign lnk.op_select_code = os_q;
  // ****************************************
  // Result tracking, delayed to match the slice latency
  // ****************************************
  logic [2:0] cyc_pipe [LAT];
  logic iss_pipe [LAT];
  logic last_pipe [LAT];
  genvar gi;
  for (gi = 0; gi < LAT; gi++) begin : g_dly
    always_ff @(posedge clk) begin
      if (rst) begin
        cyc_pipe[gi] <= '0;
        iss_pipe[gi] <= 1'b0;
        last_pipe[gi] <= 1'b0;
      end else begin
        cyc_pipe[gi] <= (gi == 0) ? cyc_q : cyc_pipe[(gi == 0) ? 0 : gi-1];
        iss_pipe[gi] <= (gi == 0) ? iss_q : iss_pipe[(gi == 0) ? 0 : gi-1];
        last_pipe[gi] <= (gi == 0) ? last_q : last_pipe[(gi == 0) ? 0 : gi-1];
      end
    end
  end
  logic [2:0] rc;
  logic rv, rl;
  assign rc = cyc_pipe[LAT-1];
  assign rv = iss_pipe[LAT-1] & lnk.acc_valid;
  assign rl = last_pipe[LAT-1];
  // ****************************************
  // Segment capture
  // ****************************************
  logic busy_d, sv_d, dn_d;
  logic [1:0] si_d;
  logic [SEG_HI_W-1:0] sd_d;
  logic [R70_W-1:0] res_d;
  logic [ACC_W-1:0] re_d;
  always_comb begin
    busy_d = (st_d != ST_IDLE);
    sv_d = 1'b0;
    si_d = seg_index;
    sd_d = '0;
    dn_d = rv & rl;
    res_d = result;
    re_d = re_part;
    if (rv) begin
      case (md_q)
        MODE_35X18: begin
          if (rc == 3'h0) begin
            res_d = '0;
            res_d[SEG_LO_W-1:0] = lnk.acc_out[SEG_LO_W-1:0];
          end else begin
            res_d[R53_W-1:SEG_LO_W] = lnk.acc_out[SEG_HI_W-1:0];
            res_d[R70_W-1:R53_W] = {(R70_W-R53_W){lnk.acc_out[SEG_HI_W-1]}};
          end
        end
        MODE_35X35: begin
          if (rc == 3'h0) begin
            sv_d = 1'b1;
            si_d = 2'h0;
            sd_d = SEG_HI_W'(lnk.acc_out[SEG_LO_W-1:0]);
            res_d = '0;
            res_d[SEG_LO_W-1:0] = lnk.acc_out[SEG_LO_W-1:0];
          end else if (rc == 3'h2) begin
            sv_d = 1'b1;
            si_d = 2'h1;
            sd_d = SEG_HI_W'(lnk.acc_out[SEG_LO_W-1:0]);
            res_d[2*SEG_LO_W-1:SEG_LO_W] = lnk.acc_out[SEG_LO_W-1:0];
          end else if (rc == 3'h3) begin
            sv_d = 1'b1;
            si_d = 2'h2;
            sd_d = lnk.acc_out[SEG_HI_W-1:0];
            res_d[R70_W-1:2*SEG_LO_W] = lnk.acc_out[SEG_HI_W-1:0];
          end
        end
        default: begin
          if (rc == 3'h1) re_d = lnk.acc_out;
          if (rc == 3'h3) res_d = R70_W'($signed(lnk.acc_out));
        end
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      seg_valid <= 1'b0;
      seg_index <= '0;
      seg_data <= '0;
      done <= 1'b0;
      result <= '0;
      re_part <= '0;
    end else begin
      busy <= busy_d;
      seg_valid <= sv_d;
      seg_index <= si_d;
      seg_data <= sd_d;
      done <= dn_d;
      result <= res_d;
      re_part <= re_d;
    end
  end
endmodule

/* File: src/mwm_slice.sv */
// Multiply-add slice: the documented device end
module mwm_slice
  import mwm_pkg::*;
  (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Controller link
  mwm_if.slice lnk
  );
  // ****************************************
  // Input stage and multiplier
  // ****************************************
  logic [OP_W-1:0] a_d, a_q, b_d, b_q;
  logic [SEL_W-1:0] s_d, s_q;
  logic [PROD_W-1:0] m_d, m_q;
  logic [SEL_W-1:0] s2_d, s2_q;
  logic [OP_W-1:0] a_use, b_use;
  logic [SEL_W-1:0] s_use, s_fin;
  logic [PROD_W-1:0] m_use;
  logic [ACC_W-1:0] p_d, p_q, sum;
  logic v_d, v_q;
  // Optional stages change latency only, never the arithmetic
  always_comb begin
    a_d = lnk.a_slice;
    b_d = lnk.b_slice;
    s_d = lnk.op_select_code;
    a_use = (PIPE_IN != 0) ? a_q : lnk.a_slice;
    b_use = (PIPE_IN != 0) ? b_q : lnk.b_slice;
    s_use = (PIPE_IN != 0) ? s_q : lnk.op_select_code;
    // Operands widened with their signs first, so the full 36-bit product survives
    m_d = $signed({{(PROD_W-OP_W){a_use[OP_W-1]}}, a_use})
      * $signed({{(PROD_W-OP_W){b_use[OP_W-1]}}, b_use});
    s2_d = s_use;
    m_use = (PIPE_OUT != 0) ? m_q : m_d;
    s_fin = (PIPE_OUT != 0) ? s2_q : s_use;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      a_q <= '0;
      b_q <= '0;
      s_q <= '0;
      m_q <= '0;
      s2_q <= '0;
    end else begin
      a_q <= a_d;
      b_q <= b_d;
      s_q <= s_d;
      m_q <= m_d;
      s2_q <= s2_d;
    end
  end
  // ****************************************
  // Adder and output register
  // ****************************************
  mwm_addsel u_add (
    .sel(s_fin),
    .prod(m_use),
    .held(p_q),
    .sum(sum)
  );
  // Every cycle loads or accumulates, so sequences run back to back
  always_comb begin
    p_d = sum;
    v_d = ~rst;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      p_q <= '0;
      v_q <= 1'b0;
    end else begin
      p_q <= p_d;
      v_q <= v_d;
    end
  end
  assign lnk.acc_out = p_q;
  assign lnk.acc_valid = v_q;
endmodule

/* File: verif/mwm_monitor.sv */
// Checker of the controller-to-slice link
// ******
// Link checks
// ******
module mwm_monitor
  import mwm_pkg::*;
  (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link signals
  input wire logic [OP_W-1:0] a_slice,
  input wire logic [OP_W-1:0] b_slice,
  input wire logic [SEL_W-1:0] op_select_code,
  input wire logic [ACC_W-1:0] acc_out,
  input wire logic acc_valid
  );
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [ACC_W-1:0] prod_x;
  logic signed [ACC_W-1:0] acc_sh;
  logic [SEL_W-1:0] op;
  // Signed helpers kept apart, so mixed compares cannot turn the shift logical
  assign prod_x = $signed(a_slice) * $signed(b_slice);
  assign acc_sh = $signed(acc_out) >>> SHIFT_W;
  assign op = op_select_code;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_load_zero:
  assert property (acc_valid && op == SEL_LOAD |=> acc_out == $past(prod_x))
    else $error("load result wrong");
  a_acc_plain:
  assert property (acc_valid && op == SEL_ACC |=> acc_out == $past(acc_out) + $past(prod_x))
    else $error("accumulate result wrong");
  a_acc_shift:
  assert property (acc_valid && op == SEL_SHACC |=> acc_out == $past(acc_sh) + $past(prod_x))
    else $error("shifted accumulate wrong");
  a_valid_up:
  assert property (!rst |=> acc_valid)
    else $error("slice not ready after reset");
  a_first_low:
  assert property (op == SEL_SHACC && $past(op) == SEL_LOAD |-> $past(a_slice[17]) == 1'b0)
    else $error("first low piece signed");
  a_mid_b:
  assert property (op == SEL_ACC && $past(op) == SEL_SHACC |-> $past(b_slice[17]) == 1'b0)
    else $error("middle low B piece signed");
  a_low_a:
  assert property (op == SEL_ACC && $past(op) == SEL_SHACC |-> a_slice[17] == 1'b0)
    else $error("third cycle low A signed");
  a_last_step:
  assert property (op == SEL_ACC && $past(op) == SEL_SHACC |=> op == SEL_SHACC)
    else $error("fourth cycle code wrong");
  // Main sequences seen on the link
  c_wide: cover property (op == SEL_LOAD ##1 op == SEL_SHACC ##1 op == SEL_ACC ##1 op == SEL_SHACC);
  c_cplx: cover property (op == SEL_LOAD ##1 op == SEL_ACC ##1 op == SEL_LOAD ##1 op == SEL_ACC);
  c_narrow: cover property (op == SEL_LOAD ##1 op == SEL_SHACC ##1 op != SEL_ACC);
endmodule

/* File: verif/test_multicycle_wide_multiplier.sv */
// Self-checking bench for the multicycle wide multiplier
// ******
// Bench
// ******
module test_multicycle_wide_multiplier
  import mwm_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  mwm_mode_t mode = MODE_35X18;
  logic [WIDE_W-1:0] op_a = '0, op_b = '0;
  logic [NARROW_W-1:0] a_im = '0, b_im = '0;
  logic busy, seg_valid, done;
  logic [1:0] seg_index;
  logic [SEG_HI_W-1:0] seg_data;
  logic [R70_W-1:0] result, segs;
  logic [ACC_W-1:0] re_part;
  logic [WIDE_W-1:0] cv [4] = '{35'h400000000, 35'h3FFFFFFFF, 35'h7FFFFFFFF, 35'h1FFFF};
  int num_errors = 0, checked = 0, cycles = 0, n;
  mwm_if lnk_inst (.clk(clk));
  mwm_slice mwm_slice_inst (.clk(clk), .rst(rst), .lnk(lnk_inst));
  mwm_ctrl mwm_ctrl_inst (.clk(clk), .rst(rst), .start(start), .mode(mode), .op_a(op_a),
    .op_b(op_b), .a_im(a_im), .b_im(b_im), .busy(busy), .seg_valid(seg_valid),
    .seg_index(seg_index), .seg_data(seg_data), .done(done), .result(result),
    .re_part(re_part), .lnk(lnk_inst));
  mwm_monitor mwm_monitor_inst (.clk(clk), .rst(rst), .a_slice(lnk_inst.a_slice),
    .b_slice(lnk_inst.b_slice), .op_select_code(lnk_inst.op_select_code),
    .acc_out(lnk_inst.acc_out), .acc_valid(lnk_inst.acc_valid));
  // 125 MHz clock
  initial forever #4 clk = ~clk;
  // Hang guard: the whole run needs under eight hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("mismatches %0d compares %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [R70_W-1:0] seen, input logic [R70_W-1:0] exp,
    input string what);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  // Reference products, signed two's complement
  function automatic logic [R70_W-1:0] exp_res(mwm_mode_t m, logic [WIDE_W-1:0] a,
    logic [WIDE_W-1:0] b, logic [NARROW_W-1:0] ai, logic [NARROW_W-1:0] bi);
    logic signed [R70_W-1:0] sa, sb;
    sa = $signed(a);
    sb = $signed(b);
    if (m == MODE_CPLX) return $signed(a[17:0]) * $signed(bi) + $signed(ai) * $signed(b[17:0]);
    return sa * sb;
  endfunction
  function automatic logic [ACC_W-1:0] exp_re(logic [WIDE_W-1:0] a, logic [WIDE_W-1:0] b,
    logic [NARROW_W-1:0] ai, logic [NARROW_W-1:0] bi);
    return $signed(a[17:0]) * $signed(b[17:0]) + $signed(ai) * $signed(bi);
  endfunction
  // One operation; poke retries start while busy, which must be ignored
  task automatic run(input mwm_mode_t m, input logic [WIDE_W-1:0] a, input logic [WIDE_W-1:0] b,
    input logic [NARROW_W-1:0] ai, input logic [NARROW_W-1:0] bi, input bit poke);
    logic [R70_W-1:0] er;
    int ecyc;
    if (m == MODE_35X18) b = 35'($signed(b[17:0]));
    // Issue cycles, plus the slice output register and the capture stage
    ecyc = ((m == MODE_35X18) ? 2 : 4) + 2 + PIPE_IN + PIPE_OUT;
    er = exp_res(m, a, b, ai, bi);
    @(posedge clk);
    start <= 1'b1;
    mode <= m;
    op_a <= a;
    op_b <= b;
    a_im <= ai;
    b_im <= bi;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    segs = '0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
      if (poke && n == 2) start <= 1'b1;
      if (poke && n == 2) op_a <= ~a;
      if (poke && n == 3) start <= 1'b0;
      #1;
      if (seg_valid === 1'b1) segs |= 70'(seg_data) << (17 * seg_index);
    end
    check(n, ecyc, "latency");
    check(result, er, "product");
    if (m == MODE_35X35) check(segs, er, "segments");
    else check(segs, 70'h0, "no segments");
    if (m == MODE_CPLX) check(re_part, exp_re(a, b, ai, bi), "real part");
    // Busy falls one edge after done, since the wait state leaves on the registered done
    @(posedge clk);
    #1;
    check(busy, 1'b0, "busy after done");
    $display("test end mode %0d", m);
  endtask
  // Corner table, random traffic, ignored restart, reset in mid-run
  initial begin
    void'($urandom(59));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      for (int i = 0; i < 4; i++) begin
        for (int j = 0; j < 4; j++) run(mwm_mode_t'(m), cv[i], cv[j], cv[j][17:0], cv[i][17:0], 1'b0);
      end
    end
    repeat (40) run(mwm_mode_t'($urandom_range(2)), 35'({$urandom, $urandom}),
      35'({$urandom, $urandom}), 18'($urandom), 18'($urandom), 1'b0);
    run(MODE_35X35, cv[0], cv[2], 18'h0, 18'h0, 1'b1);
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    check(busy, 1'b0, "busy after reset");
    run(MODE_35X35, cv[1], cv[0], 18'h0, 18'h0, 1'b0);
    complete_run();
  end
endmodule
